// file: common/xrp_pkg.sv
// shared constants for the receive word packer
package xrp_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK   = 8'h08;
    localparam logic [7:0] REG_WORD   = 8'h0C;
    localparam logic [7:0] REG_SKEW   = 8'h10;
    localparam logic [7:0] REG_COUNT  = 8'h14;
    // control field layout
    localparam int CTRL_W      = 5;
    localparam int CTRL_MODE   = 0;
    localparam int MODE_W      = 3;
    localparam int CTRL_LOWLAT = 3;
    localparam int CTRL_TXIDLE = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam int SKEW_W = 4;
    localparam logic [SKEW_W-1:0] SKEW_RST = 4'h0;
    // functional mode codes
    localparam logic [MODE_W-1:0] MODE_BASIC = 3'h0;
    localparam logic [MODE_W-1:0] MODE_PIPE  = 3'h1;
    localparam logic [MODE_W-1:0] MODE_GIGE  = 3'h2;
    localparam logic [MODE_W-1:0] MODE_SRIO  = 3'h3;
    localparam logic [MODE_W-1:0] MODE_XAUI  = 3'h4;
    // per-byte half word layout
    localparam int SYM_W    = 16;
    localparam int SYM_DATA = 0;
    localparam int BYTE_W   = 8;
    localparam int SYM_CTRL = 8;
    localparam int SYM_ERR  = 9;
    localparam int SYM_SYNC = 10;
    localparam int SYM_DISP = 11;
    localparam int SYM_PAT  = 12;
    localparam int SYM_DEL  = 13;
    localparam int SYM_INS  = 14;
    localparam int SYM_LINK = 13;
    localparam int LINK_W   = 2;
    localparam int SYM_RD   = 15;
    localparam int WORD_W   = 32;
    localparam int HI_LSB   = 16;
    // interrupt status bits
    localparam int EV_DEC  = 0;
    localparam int EV_DISP = 1;
    localparam int EV_SYNC = 2;
    localparam int EV_DEL  = 3;
    localparam int EV_INS  = 4;
    localparam int EV_W    = 5;
    localparam int CNT_W   = 16;
endpackage

// file: rtl/xrp_lane_pack.sv
// pairs two byte symbols into one receive word
`timescale 1ns/1ps
module xrp_lane_pack #(
    parameter int SYM_W = xrp_pkg::SYM_W
) (
    // clock and reset
    input  wire logic               clock_in,
    input  wire logic               srst_in,
    // symbol stream
    input  wire logic               sym_valid_in,
    input  wire logic [SYM_W-1:0]   sym_in,
    input  wire logic               pair_clr_in,
    // packed word
    output logic [2*SYM_W-1:0]      word_out,
    output logic                    word_valid_out
);
    typedef enum logic {PK_LOW, PK_HIGH} xrp_pk_state_t;
    typedef struct packed {
        xrp_pk_state_t        st;
        logic [SYM_W-1:0]     lo;
        logic [2*SYM_W-1:0]   word;
        logic                 vld;
    } xrp_pk_st_t;

    xrp_pk_st_t r_q;
    xrp_pk_st_t r_d;

    ////////////////////////////////////////////////////////////////////////////////
    // earlier symbol low, later symbol high, whole word in one edge
    always_comb begin
        r_d = r_q;
        r_d.vld = 1'b0;
        if (pair_clr_in) begin
            r_d.st = PK_LOW;
        end else if (sym_valid_in) begin
            case (r_q.st)
                PK_LOW: begin
                    r_d.lo = sym_in;
                    r_d.st = PK_HIGH;
                end
                PK_HIGH: begin
                    r_d.word = {sym_in, r_q.lo};
                    r_d.vld  = 1'b1;
                    r_d.st   = PK_LOW;
                end
                default: begin
                    r_d.st = PK_LOW;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign word_out       = r_q.word;
    assign word_valid_out = r_q.vld;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);
    a_word_whole: assert property (word_valid_out |->
        word_out == {$past(sym_in), $past(r_q.lo)} && $past(sym_valid_in))
        else $error("receive word not built from both symbols in one edge");
endmodule

// file: rtl/xrp_rx_word.sv
// receive fabric word packer with apb registers and interrupt
`timescale 1ns/1ps
// Summary of operation
// - earlier byte bits 7:0, later 23:16
// - control character flags at bits 8, 24
// - decode error flags at bits 9, 25
// - sync status at bits 10, 26
// - disparity error at bits 11, 27
// - pattern detect at bits 12, 28
// - skip deleted at 13, 29 outside pipe
// - skip inserted at 14, 30 outside pipe
// - pipe mode: link status at 14:13, 30:29
// - running disparity at bits 15, 31
// - low latency bypasses coder, aligner, rate match
// - transmit idle disables serial output driver
// - signal detect only with coder enabled
// - xaui mode adds deskew; rate match flags come in every non-pipe mode; both only outside low latency
module xrp_rx_word (
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    // apb slave
    input  wire logic [7:0]  paddr_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // decoded byte stream from the line side
    input  wire logic        byte_valid_in,
    input  wire logic [7:0]  byte_in,
    input  wire logic        ctrl_det_in,
    input  wire logic        dec_err_in,
    input  wire logic        sync_in,
    input  wire logic        disp_err_in,
    input  wire logic        pat_det_in,
    input  wire logic        rm_del_in,
    input  wire logic        rm_ins_in,
    input  wire logic [1:0]  link_stat_in,
    input  wire logic        run_disp_in,
    input  wire logic        sig_det_raw_in,
    // fabric word and line controls
    output logic [31:0]      rx_word_out,
    output logic             rx_word_valid_out,
    output logic             tx_drv_oe_out,
    output logic             sig_det_out,
    output logic             rec_clk_en_out,
    output logic             irq_out
);
    typedef struct packed {
        logic [xrp_pkg::CTRL_W-1:0] ctrl;
        logic [xrp_pkg::SKEW_W-1:0] skew;
        logic [xrp_pkg::EV_W-1:0]   mask;
        logic [xrp_pkg::EV_W-1:0]   stat;
        logic [31:0]                prdata;
        logic                       slverr;
        logic [31:0]                last;
        logic [xrp_pkg::CNT_W-1:0]  cnt;
        logic                       sync_prev;
        logic                       oe;
        logic                       sigdet;
        logic                       recclk;
        logic                       irq;
    } xrp_top_st_t;

    xrp_top_st_t r_q;
    xrp_top_st_t r_d;

    logic [xrp_pkg::MODE_W-1:0] mode;
    logic                       lowlat;
    logic                       pipe;
    logic [xrp_pkg::SYM_W-1:0]  sym;
    logic [xrp_pkg::SKEW_W-1:0] delay;
    logic                       ds_valid;
    logic [xrp_pkg::SYM_W-1:0]  ds_sym;
    logic [31:0]                word;
    logic                       word_valid;
    logic                       wr_acc;
    logic                       ctrl_wr;
    logic [xrp_pkg::EV_W-1:0]   ev;
    logic [xrp_pkg::EV_W-1:0]   clr;

    assign mode   = r_q.ctrl[xrp_pkg::CTRL_MODE +: xrp_pkg::MODE_W];
    assign lowlat = r_q.ctrl[xrp_pkg::CTRL_LOWLAT];
    assign pipe   = (mode == xrp_pkg::MODE_PIPE);

    ////////////////////////////////////////////////////////////////////////////////
    // per-byte symbol assembly
    always_comb begin
        sym = '0;
        sym[xrp_pkg::SYM_DATA +: xrp_pkg::BYTE_W] = byte_in;
        if (!lowlat) begin
            sym[xrp_pkg::SYM_CTRL] = ctrl_det_in;
            sym[xrp_pkg::SYM_ERR]  = dec_err_in;
            sym[xrp_pkg::SYM_SYNC] = sync_in;
            sym[xrp_pkg::SYM_DISP] = disp_err_in;
            sym[xrp_pkg::SYM_PAT]  = pat_det_in;
            sym[xrp_pkg::SYM_RD]   = run_disp_in;
            if (pipe) begin
                sym[xrp_pkg::SYM_LINK +: xrp_pkg::LINK_W] = link_stat_in;
            end else begin
                sym[xrp_pkg::SYM_DEL] = rm_del_in;
                sym[xrp_pkg::SYM_INS] = rm_ins_in;
            end
        end
    end

    // deskew only acts in xaui mode with the coded path
    assign delay = (mode == xrp_pkg::MODE_XAUI && !lowlat) ? r_q.skew : '0;

    xrp_skew_mem #(
        .W  (xrp_pkg::SYM_W),
        .AW (xrp_pkg::SKEW_W)
    ) u_skew (
        .clock_in     (clock_in),
        .srst_in      (srst_in),
        .wr_valid_in  (byte_valid_in),
        .wr_data_in   (sym),
        .delay_in     (delay),
        .rd_valid_out (ds_valid),
        .rd_data_out  (ds_sym)
    );

    xrp_lane_pack #(
        .SYM_W (xrp_pkg::SYM_W)
    ) u_pack (
        .clock_in       (clock_in),
        .srst_in        (srst_in),
        .sym_valid_in   (ds_valid),
        .sym_in         (ds_sym),
        .pair_clr_in    (ctrl_wr),
        .word_out       (word),
        .word_valid_out (word_valid)
    );

    assign rx_word_out       = word;
    assign rx_word_valid_out = word_valid;

    ////////////////////////////////////////////////////////////////////////////////
    // events, registers and apb access
    assign wr_acc  = psel_in && penable_in && pwrite_in;
    assign ctrl_wr = wr_acc && (paddr_in == xrp_pkg::REG_CTRL);
    assign clr     = (wr_acc && paddr_in == xrp_pkg::REG_STATUS) ?
                     pwdata_in[xrp_pkg::EV_W-1:0] : '0;

    always_comb begin
        ev = '0;
        if (word_valid) begin
            ev[xrp_pkg::EV_DEC]  = word[xrp_pkg::SYM_ERR] |
                                   word[xrp_pkg::HI_LSB + xrp_pkg::SYM_ERR];
            ev[xrp_pkg::EV_DISP] = word[xrp_pkg::SYM_DISP] |
                                   word[xrp_pkg::HI_LSB + xrp_pkg::SYM_DISP];
            ev[xrp_pkg::EV_SYNC] = r_q.sync_prev & ~word[xrp_pkg::HI_LSB + xrp_pkg::SYM_SYNC];
            ev[xrp_pkg::EV_DEL]  = !pipe && (word[xrp_pkg::SYM_DEL] |
                                   word[xrp_pkg::HI_LSB + xrp_pkg::SYM_DEL]);
            ev[xrp_pkg::EV_INS]  = !pipe && (word[xrp_pkg::SYM_INS] |
                                   word[xrp_pkg::HI_LSB + xrp_pkg::SYM_INS]);
        end
    end

    always_comb begin
        r_d = r_q;
        for (int i = 0; i < xrp_pkg::EV_W; i++) begin
            r_d.stat[i] = (r_q.stat[i] & ~clr[i]) | ev[i];
        end
        if (word_valid) begin
            r_d.last      = word;
            r_d.cnt       = xrp_pkg::CNT_W'(r_q.cnt + 1'b1);
            r_d.sync_prev = word[xrp_pkg::HI_LSB + xrp_pkg::SYM_SYNC];
        end
        if (psel_in && !penable_in) begin
            r_d.slverr = 1'b0;
            case (paddr_in)
                xrp_pkg::REG_CTRL:   r_d.prdata = 32'(r_q.ctrl);
                xrp_pkg::REG_STATUS: r_d.prdata = 32'(r_q.stat);
                xrp_pkg::REG_MASK:   r_d.prdata = 32'(r_q.mask);
                xrp_pkg::REG_WORD:   r_d.prdata = r_q.last;
                xrp_pkg::REG_SKEW:   r_d.prdata = 32'(r_q.skew);
                xrp_pkg::REG_COUNT:  r_d.prdata = 32'(r_q.cnt);
                default: begin
                    r_d.prdata = '0;
                    r_d.slverr = 1'b1;
                end
            endcase
        end
        if (wr_acc) begin
            case (paddr_in)
                xrp_pkg::REG_CTRL: r_d.ctrl = pwdata_in[xrp_pkg::CTRL_W-1:0];
                xrp_pkg::REG_MASK: r_d.mask = pwdata_in[xrp_pkg::EV_W-1:0];
                xrp_pkg::REG_SKEW: r_d.skew = pwdata_in[xrp_pkg::SKEW_W-1:0];
                default: r_d.mask = r_q.mask;
            endcase
        end
        r_d.oe     = !r_q.ctrl[xrp_pkg::CTRL_TXIDLE];
        r_d.sigdet = sig_det_raw_in && !lowlat;
        r_d.recclk = (mode == xrp_pkg::MODE_GIGE);
        r_d.irq    = |(r_q.stat & r_q.mask);
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            r_q      <= '0;
            r_q.ctrl <= xrp_pkg::CTRL_RST;
            r_q.skew <= xrp_pkg::SKEW_RST;
        end else begin
            r_q <= r_d;
        end
    end

    assign prdata_out     = r_q.prdata;
    assign pready_out     = 1'b1;
    assign pslverr_out    = r_q.slverr && psel_in && penable_in;
    assign tx_drv_oe_out  = r_q.oe;
    assign sig_det_out    = r_q.sigdet;
    assign rec_clk_en_out = r_q.recclk;
    assign irq_out        = r_q.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    logic [xrp_pkg::CTRL_W+xrp_pkg::SKEW_W-1:0] cfg_h1;
    logic [xrp_pkg::CTRL_W+xrp_pkg::SKEW_W-1:0] cfg_h2;
    logic                                       steady;
    always_ff @(posedge clock_in) begin
        cfg_h1 <= {r_q.ctrl, r_q.skew};
        cfg_h2 <= cfg_h1;
    end
    assign steady = (cfg_h1 == {r_q.ctrl, r_q.skew}) && (cfg_h2 == cfg_h1) && (delay == '0);

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    a_hi_byte_data: assert property (word_valid && steady |->
        word[23:16] == $past(byte_in, 2))
        else $error("high byte not the later received byte");
    a_hi_ctrl_flag: assert property (word_valid && steady && !lowlat |->
        word[24] == $past(ctrl_det_in, 2))
        else $error("control flag of high byte misplaced");
    a_hi_err_flag: assert property (word_valid && steady && !lowlat |->
        word[25] == $past(dec_err_in, 2) && word[27] == $past(disp_err_in, 2))
        else $error("error flags of high byte misplaced");
    a_rm_delete: assert property (word_valid && steady && !lowlat && !pipe |->
        word[29] == $past(rm_del_in, 2) && word[30] == $past(rm_ins_in, 2))
        else $error("rate match flags of high byte misplaced");
    a_pipe_link: assert property (word_valid && steady && !lowlat && pipe |->
        word[30:29] == $past(link_stat_in, 2))
        else $error("link status of high byte misplaced");
    a_run_disp: assert property (word_valid && steady && !lowlat |->
        word[31] == $past(run_disp_in, 2))
        else $error("running disparity of high byte misplaced");
    a_lowlat_bypass: assert property (word_valid && steady && lowlat |->
        word[31:24] == 8'h00 && word[15:8] == 8'h00)
        else $error("flags present in low latency mode");
    a_tx_idle_drv: assert property (r_q.ctrl[xrp_pkg::CTRL_TXIDLE] |=>
        !tx_drv_oe_out)
        else $error("driver enabled during transmit idle");
    a_sigdet_gate: assert property (lowlat |=> !sig_det_out)
        else $error("signal detect offered with coder bypassed");
    a_recclk_gige: assert property ((mode == xrp_pkg::MODE_GIGE) |=> rec_clk_en_out)
        else $error("recovered clock not exposed in gigabit mode");
    a_set_wins: assert property (ev[xrp_pkg::EV_DEC] && clr[xrp_pkg::EV_DEC] |=>
        r_q.stat[xrp_pkg::EV_DEC])
        else $error("status event lost against clear");
    a_irq_level: assert property (irq_out == $past(|(r_q.stat & r_q.mask)))
        else $error("interrupt not following masked status");

    c_pipe_word: cover property (word_valid && pipe);
    c_xaui_skew: cover property (word_valid && delay != '0);
    c_irq_rise: cover property (!irq_out ##1 irq_out);
endmodule

// file: rtl/xrp_skew_mem.sv
// lane deskew buffer with registered read data
`timescale 1ns/1ps
module xrp_skew_mem #(
    parameter int W  = xrp_pkg::SYM_W,
    parameter int AW = xrp_pkg::SKEW_W
) (
    // clock and reset
    input  wire logic          clock_in,
    input  wire logic          srst_in,
    // write side
    input  wire logic          wr_valid_in,
    input  wire logic [W-1:0]  wr_data_in,
    input  wire logic [AW-1:0] delay_in,
    // read side
    output logic               rd_valid_out,
    output logic [W-1:0]       rd_data_out
);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [W-1:0]  rd;
        logic          vld;
    } xrp_mem_st_t;

    xrp_mem_st_t r_q;
    xrp_mem_st_t r_d;
    logic [W-1:0] mem_q [2**AW];

    ////////////////////////////////////////////////////////////////////////////////
    // read the symbol written delay_in writes ago
    always_comb begin
        r_d = r_q;
        r_d.vld = wr_valid_in;
        if (wr_valid_in) begin
            r_d.wp = AW'(r_q.wp + 1'b1);
            r_d.rd = (delay_in == '0) ? wr_data_in : mem_q[AW'(r_q.wp - delay_in)];
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (wr_valid_in) begin
            mem_q[r_q.wp] <= wr_data_in;
        end
    end

    assign rd_valid_out = r_q.vld;
    assign rd_data_out  = r_q.rd;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);
    a_mem_latency: assert property (rd_valid_out == $past(wr_valid_in))
        else $error("deskew valid not one cycle behind write");
endmodule

// file: tb/xrp_line_src.sv
// line-side byte source model feeding decoded bytes and flags
`timescale 1ns/1ps
module xrp_line_src (
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    // requests from the bench
    input  wire logic        send_in,
    input  wire logic [15:0] sym_in,
    input  wire logic [1:0]  link_in,
    // decoded byte stream
    output logic             byte_valid_out,
    output logic [15:0]      sym_out,
    output logic [1:0]       link_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // one byte per edge while asked; between bytes the lines show the inverse
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            byte_valid_out <= 1'b0;
            sym_out        <= 16'h0000;
            link_out       <= 2'h0;
        end else if (send_in) begin
            byte_valid_out <= 1'b1;
            sym_out        <= sym_in;
            link_out       <= link_in;
        end else begin
            byte_valid_out <= 1'b0;
            sym_out        <= ~sym_out;
            link_out       <= ~link_out;
        end
    end
endmodule

// file: tb/xrp_rx_word_tb.sv
// self-checking testbench for the receive word packer
`timescale 1ns/1ps
module xrp_rx_word_tb;
    logic        clock_in;
    logic        srst_in;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rx_word;
    logic [31:0] rd;
    logic        er;
    logic        send;
    logic        byte_valid;
    logic        sig_raw;
    logic        word_valid;
    logic        tx_oe;
    logic        sig_det;
    logic        rclk_en;
    logic        irq;
    logic [15:0] sym;
    logic [15:0] lsym;
    logic [1:0]  link;
    logic [1:0]  llink;
    int          err_total;
    int          total_checks;

    ////////////////////////////////////////////////////////////////////////////////
    // design and line-side model
    xrp_rx_word u_dut (
        .clock_in(clock_in), .srst_in(srst_in), .paddr_in(paddr), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .byte_valid_in(byte_valid), .byte_in(lsym[7:0]), .ctrl_det_in(lsym[8]),
        .dec_err_in(lsym[9]), .sync_in(lsym[10]), .disp_err_in(lsym[11]),
        .pat_det_in(lsym[12]), .rm_del_in(lsym[13]), .rm_ins_in(lsym[14]),
        .link_stat_in(llink), .run_disp_in(lsym[15]), .sig_det_raw_in(sig_raw),
        .rx_word_out(rx_word), .rx_word_valid_out(word_valid), .tx_drv_oe_out(tx_oe),
        .sig_det_out(sig_det), .rec_clk_en_out(rclk_en), .irq_out(irq)
    );
    xrp_line_src u_src (
        .clock_in(clock_in), .srst_in(srst_in), .send_in(send), .sym_in(sym),
        .link_in(link), .byte_valid_out(byte_valid), .sym_out(lsym), .link_out(llink)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // tasks
    task finish_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_total++;
            finish_test();
        end else begin
            rd = prdata;
            er = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge clock_in);
        end
    endtask

    task send_pair(input logic [15:0] lo, input logic [15:0] hi, input logic [1:0] lk);
        send <= 1'b1;
        sym  <= lo;
        link <= lk;
        @(posedge clock_in);
        sym  <= hi;
        link <= ~lk;
        @(posedge clock_in);
        send <= 1'b0;
        @(posedge clock_in);
    endtask

    task get_word;
        int n;
        n = 0;
        while (word_valid !== 1'b1 && n < 100) begin
            @(posedge clock_in);
            n++;
        end
        if (word_valid !== 1'b1) begin
            err_total++;
            $display("BAD t=%0t no word", $time);
            finish_test();
        end
    endtask

    function automatic logic [15:0] exp_half(logic [15:0] s, logic [1:0] lk,
                                             logic [2:0] md, logic ll);
        logic [15:0] h;
        h = s;
        if (md == xrp_pkg::MODE_PIPE) h[14:13] = lk;
        if (ll) h[15:8] = 8'h00;
        return h;
    endfunction

    task pair(input logic [15:0] lo, input logic [15:0] hi, input logic [1:0] lk,
              input logic [2:0] md, input logic ll);
        send_pair(lo, hi, lk);
        get_word();
        chk(rx_word, {exp_half(hi, ~lk, md, ll), exp_half(lo, lk, md, ll)}, "word");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // clock, watchdog and main sequence
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end

    initial begin
        repeat (20000) @(posedge clock_in);
        err_total++;
        finish_test();
    end

    initial begin
        srst_in = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        send = 1'b0;
        sym = 16'h0000;
        link = 2'h0;
        sig_raw = 1'b1;
        err_total = 0;
        total_checks = 0;
        repeat (3) @(posedge clock_in);
        srst_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        chk(32'(tx_oe), 32'h1, "driver on");
        apb(1'b1, xrp_pkg::REG_WORD, 32'hFFFF_FFFF);
        apb(1'b1, xrp_pkg::REG_COUNT, 32'hFFFF_FFFF);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, 32'h0, "reset value");
            chk(32'(er), 32'h0, "slverr");
        end
        apb(1'b0, 8'h18, 32'h0);
        chk(32'(er), 32'h1, "unmapped slverr");
        chk(32'(sig_det), 32'h1, "sig det coded");
        chk(32'(rclk_en), 32'h0, "rec clk basic");
        pair(16'hA5C3, 16'h5A3C, 2'h0, xrp_pkg::MODE_BASIC, 1'b0);
        apb(1'b0, xrp_pkg::REG_COUNT, 32'h0);
        chk(rd, 32'h1, "count");
        apb(1'b0, xrp_pkg::REG_STATUS, 32'h0);
        chk(rd, 32'h0000_001B, "status events");
        apb(1'b1, xrp_pkg::REG_CTRL, 32'(xrp_pkg::MODE_PIPE));
        pair(16'h7F11, 16'h8022, 2'h2, xrp_pkg::MODE_PIPE, 1'b0);
        apb(1'b1, xrp_pkg::REG_CTRL, 32'(xrp_pkg::MODE_GIGE));
        @(posedge clock_in);
        chk(32'(rclk_en), 32'h1, "rec clk gige");
        pair(16'h8144, 16'h0155, 2'h1, xrp_pkg::MODE_GIGE, 1'b0);
        apb(1'b1, xrp_pkg::REG_CTRL, 32'h0000_0008);
        @(posedge clock_in);
        chk(32'(sig_det), 32'h0, "sig det low lat");
        pair(16'hFF66, 16'hFF77, 2'h3, xrp_pkg::MODE_BASIC, 1'b1);
        apb(1'b1, xrp_pkg::REG_CTRL, 32'h0000_0010);
        @(posedge clock_in);
        chk(32'(tx_oe), 32'h0, "driver idle");
        apb(1'b1, xrp_pkg::REG_CTRL, 32'h0000_0000);
        @(posedge clock_in);
        chk(32'(tx_oe), 32'h1, "driver back");
        apb(1'b1, xrp_pkg::REG_STATUS, 32'h0000_001F);
        apb(1'b1, xrp_pkg::REG_MASK, 32'h0000_0000);
        pair(16'h0611, 16'h0422, 2'h0, xrp_pkg::MODE_BASIC, 1'b0);
        repeat (3) @(posedge clock_in);
        apb(1'b0, xrp_pkg::REG_STATUS, 32'h0);
        chk(rd, 32'h1, "status dec");
        chk(32'(irq), 32'h0, "irq masked");
        apb(1'b1, xrp_pkg::REG_MASK, 32'h0000_0001);
        @(posedge clock_in);
        chk(32'(irq), 32'h1, "irq on");
        apb(1'b1, xrp_pkg::REG_STATUS, 32'h0000_0001);
        apb(1'b0, xrp_pkg::REG_STATUS, 32'h0);
        chk(rd, 32'h0, "status clear");
        chk(32'(irq), 32'h0, "irq off");
        // clear lands in the same cycle as the word that sets the bit
        fork
            send_pair(16'h0200, 16'h0000, 2'h0);
            begin
                repeat (3) @(posedge clock_in);
                apb(1'b1, xrp_pkg::REG_STATUS, 32'h0000_0001);
            end
        join
        apb(1'b0, xrp_pkg::REG_STATUS, 32'h0);
        chk(rd, 32'h0000_0005, "set beats clear");
        apb(1'b1, xrp_pkg::REG_SKEW, 32'h0000_0002);
        apb(1'b0, xrp_pkg::REG_SKEW, 32'h0);
        chk(rd, 32'h2, "skew");
        apb(1'b1, xrp_pkg::REG_CTRL, 32'(xrp_pkg::MODE_XAUI));
        send_pair(16'h6499, 16'h04AA, 2'h0);
        send_pair(16'h04BB, 16'h04CC, 2'h0);
        get_word();
        chk(rx_word, 32'h04AA_6499, "deskewed word");
        finish_test();
    end
endmodule
